// [fifo_rbm_pkg.sv]
`default_nettype none
package fifo_rbm_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] AE_OFFSET_OFS = 8'h04;
   localparam logic [7:0] AF_OFFSET_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h10;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int CTRL_FALL_THROUGH_MODE_BIT = 0;
   localparam int ST_EMPTY_N_BIT = 0;
   localparam int ST_FULL_N_BIT = 1;
   localparam int ST_AE_N_BIT = 2;
   localparam int ST_AF_N_BIT = 3;
   localparam int ST_OR_BIT = 4;
   localparam int ST_MAIL_N_BIT = 5;
   localparam int ST_LEVEL_LSB = 8;
   localparam int IRQ_MAIL_BIT = 0;
   localparam int IRQ_WR_REFUSED_BIT = 1;
   localparam int IRQ_RD_REFUSED_BIT = 2;
   localparam int IRQ_W = 3;
   localparam logic [31:0] OFFSET_RESET = 32'h0000_0008;
   localparam logic CTRL_FALL_THROUGH_MODE_RESET = 1'b0;

   // ------------------------------------------------------------
   // data layout: long word, word half, byte
   // ------------------------------------------------------------
   localparam int LONG_W = 36;
   localparam int HALF_W = 18;
   localparam int BYTE_W = 9;
   localparam logic [1:0] LAST_LONG = 2'h0;
   localparam logic [1:0] LAST_WORD = 2'h1;
   localparam logic [1:0] LAST_BYTE = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {SIZE_LONG, SIZE_WORD, SIZE_BYTE} bus_size_t;
endpackage
`default_nettype wire

// [fifo_read_bus_match_flags.sv]
`default_nettype none
module fifo_read_bus_match_flags #(
   parameter int DEPTH = 16384
) (
   input wire logic sys_clk_i, // system clock, 100 MHz
   input wire logic rst_i, // synchronous reset, active high
   // ahb-lite slave
   input wire logic hsel_i, // slave select
   input wire logic [31:0] haddr_i, // byte address
   input wire logic [1:0] htrans_i, // transfer type
   input wire logic hwrite_i, // write when high
   input wire logic [2:0] hsize_i, // word only
   input wire logic [31:0] hwdata_i, // write data
   input wire logic hready_i, // bus ready
   output logic hreadyout_o, // always ready
   output logic hresp_o, // always okay
   output logic [31:0] hrdata_o, // read data
   output logic irq_o, // level interrupt
   // strap and static size pins
   input wire logic bus_match_select_i, // high: word or byte size
   input wire logic size_select_i, // high: byte, low: word
   input wire logic endian_order_select_i, // high: big-endian, sampled in reset
   // input port
   input wire logic input_port_clock_i, // input port clock edge enable
   input wire logic input_port_select_n_i, // port select, active low
   input wire logic a_write_i, // write when high
   input wire logic input_mailbox_select_i, // high: mailbox
   input wire logic [35:0] a_data_i, // write data
   output logic full_indicator_n_o, // full flag, active low
   output logic input_space_ready_o, // fall-through input ready
   output logic almost_full_indicator_n_o, // almost-full, active low
   // output port
   input wire logic output_port_clock_i, // output port clock edge enable
   input wire logic output_port_select_n_i, // port select, active low
   input wire logic b_read_i, // read when high
   input wire logic output_mailbox_select_i, // high: mailbox
   output logic [35:0] b_data_o, // read data
   output logic empty_indicator_n_o, // empty flag, active low
   output logic output_ready_o, // fall-through output ready
   output logic almost_empty_indicator_n_o, // almost-empty, active low
   output logic a_to_b_mail_flag_n_o // mail waiting, active low
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
   localparam logic [PW-1:0] ONE_P = {{AW{1'b0}}, 1'b1};

   // ------------------------------------------------------------
   // piece selection helpers
   // ------------------------------------------------------------
   // upper lanes are driven zero where the port size leaves them undefined
   function automatic logic [35:0] piece(input logic [35:0] w, input logic [1:0] k,
                                          input fifo_rbm_pkg::bus_size_t sz, input logic big);
      logic [1:0] b;
      piece = 36'h0_0000_0000;
      b = big ? 2'(2'h3 - k) : k;
      case (sz)
         fifo_rbm_pkg::SIZE_WORD: begin
            piece[17:0] = (big ^ k[0]) ? w[35:18] : w[17:0];
         end
         fifo_rbm_pkg::SIZE_BYTE: begin
            piece[8:0] = w[9*b +: 9];
         end
         default: begin
            piece = w;
         end
      endcase
   endfunction

   function automatic logic [1:0] last_piece(input fifo_rbm_pkg::bus_size_t sz);
      case (sz)
         fifo_rbm_pkg::SIZE_WORD: last_piece = fifo_rbm_pkg::LAST_WORD;
         fifo_rbm_pkg::SIZE_BYTE: last_piece = fifo_rbm_pkg::LAST_BYTE;
         default: last_piece = fifo_rbm_pkg::LAST_LONG;
      endcase
   endfunction

   // ------------------------------------------------------------
   // configuration
   // ------------------------------------------------------------
   fifo_rbm_pkg::bus_size_t size_mode;
   logic big_endian;
   logic fall_through_mode;
   logic [31:0] ae_offset;
   logic [31:0] af_offset;
   logic [fifo_rbm_pkg::IRQ_W-1:0] irq_status;
   logic [fifo_rbm_pkg::IRQ_W-1:0] irq_mask;

   // size pins are expected static, so they are decoded directly
   assign size_mode = !bus_match_select_i ? fifo_rbm_pkg::SIZE_LONG :
                      (size_select_i ? fifo_rbm_pkg::SIZE_BYTE : fifo_rbm_pkg::SIZE_WORD);

   // endian order is caught while reset is held, then frozen
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         big_endian <= endian_order_select_i;
      end
   end

   // ------------------------------------------------------------
   // storage and pointers
   // ------------------------------------------------------------
   logic [35:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [PW-1:0] wr_s1, wr_s2, rd_s1, rd_s2;
   logic [PW-1:0] level_a, level_b;
   logic wr_req, wr_ok, rd_req;

   // input port requests
   assign wr_req = input_port_clock_i & ~input_port_select_n_i & a_write_i &
                   ~input_mailbox_select_i;
   assign level_a = PW'(wr_ptr - rd_s2);
   assign wr_ok = wr_req & full_indicator_n_o;
   assign next_wr_ptr = wr_ok ? PW'(wr_ptr + ONE_P) : wr_ptr;

   // array keeps whole long words; narrowing happens only on the way out
   always_ff @(posedge sys_clk_i) begin
      if (wr_ok) begin
         mem[wr_ptr[AW-1:0]] <= a_data_i;
      end
   end

   // pointers cross through two stages clocked by the receiving port's edges
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         wr_s1 <= '0;
         wr_s2 <= '0;
         rd_s1 <= '0;
         rd_s2 <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         if (output_port_clock_i) begin
            wr_s1 <= wr_ptr;
            wr_s2 <= wr_s1;
         end
         if (input_port_clock_i) begin
            rd_s1 <= rd_ptr;
            rd_s2 <= rd_s1;
         end
      end
   end

   // input-side flags see reads only via the synchronised read pointer
   assign full_indicator_n_o = (level_a != DEPTH_P);
   assign input_space_ready_o = fall_through_mode & full_indicator_n_o;
   assign almost_full_indicator_n_o =
      (level_a < PW'(DEPTH_P - af_offset[PW-1:0]));

   // ------------------------------------------------------------
   // output port read path
   // ------------------------------------------------------------
   logic [35:0] fifo_out, next_fifo_out, cur_word;
   logic [1:0] idx, next_idx, last_idx;
   logic out_valid, next_out_valid;
   logic rd_refused;

   assign rd_req = output_port_clock_i & ~output_port_select_n_i & b_read_i &
                   ~output_mailbox_select_i;
   assign level_b = PW'(wr_s2 - rd_ptr);
   assign cur_word = mem[rd_ptr[AW-1:0]];
   assign last_idx = last_piece(size_mode);

   // the read pointer moves only when the final piece leaves,
   // so level and flags treat a partly read long word as still stored
   always_comb begin
      next_fifo_out = fifo_out;
      next_idx = idx;
      next_out_valid = out_valid;
      next_rd_ptr = rd_ptr;
      rd_refused = 1'b0;
      if (!fall_through_mode) begin
         if (rd_req && level_b != '0) begin
            next_fifo_out = piece(cur_word, idx, size_mode, big_endian);
            if (idx == last_idx) begin
               next_rd_ptr = PW'(rd_ptr + ONE_P);
               next_idx = 2'h0;
            end else begin
               next_idx = 2'(idx + 2'h1);
            end
         end else if (rd_req) begin
            rd_refused = 1'b1;
         end
      end else if (out_valid && rd_req) begin
         if (idx != last_idx) begin
            next_idx = 2'(idx + 2'h1);
            next_fifo_out = piece(cur_word, next_idx, size_mode, big_endian);
         end else begin
            next_rd_ptr = PW'(rd_ptr + ONE_P);
            next_idx = 2'h0;
            if (level_b > ONE_P) begin
               next_fifo_out = piece(mem[next_rd_ptr[AW-1:0]], 2'h0, size_mode, big_endian);
            end else begin
               next_out_valid = 1'b0;
            end
         end
      end else if (!out_valid && output_port_clock_i && level_b != '0) begin
         // two sync stages plus this load give the third output edge
         next_fifo_out = piece(cur_word, 2'h0, size_mode, big_endian);
         next_out_valid = 1'b1;
      end else if (rd_req) begin
         rd_refused = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         fifo_out <= 36'h0_0000_0000;
         idx <= 2'h0;
         out_valid <= 1'b0;
      end else begin
         fifo_out <= next_fifo_out;
         idx <= next_idx;
         out_valid <= next_out_valid;
      end
   end

   // output-side flags see writes only via the synchronised write pointer
   assign empty_indicator_n_o = (level_b != '0);
   assign output_ready_o = fall_through_mode & out_valid;
   assign almost_empty_indicator_n_o = (level_b > ae_offset[PW-1:0]);

   // ------------------------------------------------------------
   // input-to-output mailbox
   // ------------------------------------------------------------
   logic [35:0] mailbox, next_mailbox, mail_mask;
   logic mail_n, next_mail_n, mail_wr, mail_rd, mail_arrived;

   // mask follows the output port size; endian order never applies
   assign mail_mask = (size_mode == fifo_rbm_pkg::SIZE_WORD) ? 36'h0_0003_ffff :
                      (size_mode == fifo_rbm_pkg::SIZE_BYTE) ? 36'h0_0000_01ff :
                      36'hf_ffff_ffff;
   assign mail_wr = input_port_clock_i & ~input_port_select_n_i & a_write_i &
                    input_mailbox_select_i;
   assign mail_rd = output_port_clock_i & ~output_port_select_n_i & b_read_i &
                    output_mailbox_select_i;

   // a waiting letter blocks further writes until the output port reads it
   always_comb begin
      next_mailbox = mailbox;
      next_mail_n = mail_n;
      mail_arrived = 1'b0;
      if (mail_rd) begin
         next_mail_n = 1'b1;
      end
      if (mail_wr && mail_n) begin
         next_mailbox = a_data_i & mail_mask;
         next_mail_n = 1'b0;
         mail_arrived = 1'b1;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         mailbox <= 36'h0_0000_0000;
         mail_n <= 1'b1;
      end else begin
         mailbox <= next_mailbox;
         mail_n <= next_mail_n;
      end
   end

   assign a_to_b_mail_flag_n_o = mail_n;
   assign b_data_o = output_mailbox_select_i ? mailbox : fifo_out;

   // ------------------------------------------------------------
   // ahb-lite register slave
   // ------------------------------------------------------------
   logic ahb_wr, next_ahb_wr;
   logic [7:0] ahb_addr, next_ahb_addr;
   logic [31:0] next_hrdata, status_word;
   logic next_fall_through_mode;
   logic [31:0] next_ae_offset, next_af_offset;
   logic [fifo_rbm_pkg::IRQ_W-1:0] next_irq_status, next_irq_mask, irq_events;
   logic addr_phase;

   assign addr_phase = hsel_i & htrans_i[1] & hready_i;
   assign irq_events = {rd_refused, wr_req & ~full_indicator_n_o, mail_arrived};

   always_comb begin
      status_word = 32'h0000_0000;
      status_word[fifo_rbm_pkg::ST_EMPTY_N_BIT] = empty_indicator_n_o;
      status_word[fifo_rbm_pkg::ST_FULL_N_BIT] = full_indicator_n_o;
      status_word[fifo_rbm_pkg::ST_AE_N_BIT] = almost_empty_indicator_n_o;
      status_word[fifo_rbm_pkg::ST_AF_N_BIT] = almost_full_indicator_n_o;
      status_word[fifo_rbm_pkg::ST_OR_BIT] = out_valid;
      status_word[fifo_rbm_pkg::ST_MAIL_N_BIT] = mail_n;
      status_word[fifo_rbm_pkg::ST_LEVEL_LSB +: PW] = level_b;
   end

   // read data is fetched in the address phase so the slave needs no wait state
   always_comb begin
      next_ahb_wr = addr_phase & hwrite_i;
      next_ahb_addr = addr_phase ? haddr_i[7:0] : ahb_addr;
      next_hrdata = hrdata_o;
      next_fall_through_mode = fall_through_mode;
      next_ae_offset = ae_offset;
      next_af_offset = af_offset;
      next_irq_mask = irq_mask;
      next_irq_status = irq_status;
      if (addr_phase && !hwrite_i) begin
         case (haddr_i[7:0])
            fifo_rbm_pkg::CTRL_OFS: next_hrdata = {31'h0000_0000, fall_through_mode};
            fifo_rbm_pkg::AE_OFFSET_OFS: next_hrdata = ae_offset;
            fifo_rbm_pkg::AF_OFFSET_OFS: next_hrdata = af_offset;
            fifo_rbm_pkg::STATUS_OFS: next_hrdata = status_word;
            fifo_rbm_pkg::IRQ_STATUS_OFS: next_hrdata = {29'h0000_0000, irq_status};
            fifo_rbm_pkg::IRQ_MASK_OFS: next_hrdata = {29'h0000_0000, irq_mask};
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
      if (ahb_wr) begin
         case (ahb_addr)
            fifo_rbm_pkg::CTRL_OFS: next_fall_through_mode = hwdata_i[fifo_rbm_pkg::CTRL_FALL_THROUGH_MODE_BIT];
            fifo_rbm_pkg::AE_OFFSET_OFS: next_ae_offset = hwdata_i;
            fifo_rbm_pkg::AF_OFFSET_OFS: next_af_offset = hwdata_i;
            fifo_rbm_pkg::IRQ_STATUS_OFS: next_irq_status = irq_status & ~hwdata_i[2:0];
            fifo_rbm_pkg::IRQ_MASK_OFS: next_irq_mask = hwdata_i[2:0];
            default: next_fall_through_mode = fall_through_mode;
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_irq_status = next_irq_status | irq_events;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ahb_wr <= 1'b0;
         ahb_addr <= 8'h00;
         hrdata_o <= 32'h0000_0000;
         fall_through_mode <= fifo_rbm_pkg::CTRL_FALL_THROUGH_MODE_RESET;
         ae_offset <= fifo_rbm_pkg::OFFSET_RESET;
         af_offset <= fifo_rbm_pkg::OFFSET_RESET;
         irq_status <= '0;
         irq_mask <= '0;
      end else begin
         ahb_wr <= next_ahb_wr;
         ahb_addr <= next_ahb_addr;
         hrdata_o <= next_hrdata;
         fall_through_mode <= next_fall_through_mode;
         ae_offset <= next_ae_offset;
         af_offset <= next_af_offset;
         irq_status <= next_irq_status;
         irq_mask <= next_irq_mask;
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign irq_o = |(irq_status & irq_mask);
endmodule
`default_nettype wire

// [fifo_rbm_checker.sv]
`default_nettype none
module fifo_rbm_checker #(
   parameter int DEPTH = 16
) (
   input wire logic sys_clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic bus_match_select_i, // narrow bus
   input wire logic size_select_i, // byte size
   input wire logic input_port_clock_i, // input edge
   input wire logic input_port_select_n_i, // input select
   input wire logic a_write_i, // input write
   input wire logic input_mailbox_select_i, // input mailbox
   input wire logic output_port_clock_i, // output edge
   input wire logic output_port_select_n_i, // output select
   input wire logic b_read_i, // output read
   input wire logic output_mailbox_select_i, // output mailbox
   input wire logic [35:0] b_data_o, // output data
   input wire logic full_indicator_n_o, // full
   input wire logic input_space_ready_o, // input ready
   input wire logic almost_full_indicator_n_o, // almost full
   input wire logic empty_indicator_n_o, // empty
   input wire logic output_ready_o, // output ready
   input wire logic almost_empty_indicator_n_o, // almost empty
   input wire logic a_to_b_mail_flag_n_o // mail flag
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mail_wr;
   logic mail_rd;
   // ----------------------------------------
   // mailbox strobes, as seen on the pins
   // ----------------------------------------
   assign mail_wr = input_port_clock_i & ~input_port_select_n_i & a_write_i
      & input_mailbox_select_i;
   assign mail_rd = output_port_clock_i & ~output_port_select_n_i & b_read_i
      & output_mailbox_select_i;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // flags only rise on their own port's edges or an offset or mode register write, since pointers cross two stages
   mail_set_a: assert property (mail_wr && a_to_b_mail_flag_n_o |=> !a_to_b_mail_flag_n_o)
      else $error("mail flag not low after mailbox write");
   mail_clear_a: assert property (mail_rd && !mail_wr |=> a_to_b_mail_flag_n_o)
      else $error("mail flag not high after mailbox read");
   mail_hold_a: assert property ($rose(a_to_b_mail_flag_n_o) |-> $past(mail_rd))
      else $error("mail flag rose without a read");
   empty_sync_a: assert property ($rose(empty_indicator_n_o) |-> $past(output_port_clock_i))
      else $error("empty flag rose off an output edge");
   full_sync_a: assert property ($rose(full_indicator_n_o) |-> $past(input_port_clock_i))
      else $error("full flag rose off an input edge");
   ae_sync_a: assert property ($rose(almost_empty_indicator_n_o) |-> $past(output_port_clock_i))
      else $error("almost empty rose off an output edge");
   af_sync_a: assert property ($rose(almost_full_indicator_n_o) |-> $past(input_port_clock_i))
      else $error("almost full rose off an input edge");
   or_sync_a: assert property ($rose(output_ready_o) |-> $past(output_port_clock_i))
      else $error("output ready rose off an output edge");
   ir_full_a: assert property (input_space_ready_o |-> full_indicator_n_o)
      else $error("input ready while full");
   word_lanes_a: assert property (bus_match_select_i |-> b_data_o[35:18] == 18'h0)
      else $error("upper lanes driven in word mode");
   byte_lanes_a: assert property (bus_match_select_i && size_select_i |-> b_data_o[35:9] == 27'h0)
      else $error("upper lanes driven in byte mode");
endmodule
bind fifo_read_bus_match_flags fifo_rbm_checker #(.DEPTH(DEPTH)) fifo_rbm_checker_i (.*);
`default_nettype wire

// [fifo_far_side_model.sv]
`default_nettype none
module fifo_far_side_model (
   input wire logic sys_clk_i, // system clock
   input wire logic slow_i, // high: sparse port edges
   output logic input_port_clock_o, // input port edge
   output logic output_port_clock_o // output port edge
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] in_cnt = 3'h0;
   logic [2:0] out_cnt = 3'h0;
   // unlike periods let the two port edges drift, so both skew cases occur
   always_ff @(posedge sys_clk_i) begin
      in_cnt <= (in_cnt >= (slow_i ? 3'h4 : 3'h2)) ? 3'h0 : in_cnt + 3'h1;
      out_cnt <= (out_cnt >= (slow_i ? 3'h6 : 3'h1)) ? 3'h0 : out_cnt + 3'h1;
   end
   assign input_port_clock_o = (in_cnt == 3'h0);
   assign output_port_clock_o = (out_cnt == 3'h0);
endmodule
`default_nettype wire

// [fifo_read_bus_match_flags_tb_top.sv]
`default_nettype none
module fifo_read_bus_match_flags_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic slow = 1'b0;
   logic bms = 1'b0;
   logic szs = 1'b0;
   logic bes = 1'b0;
   logic a_sel_n = 1'b1;
   logic a_mb = 1'b0;
   logic b_sel_n = 1'b1;
   logic b_mb = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [35:0] a_data = 36'h0;
   logic hreadyout, irq, in_clk, out_clk, full_n, ir, af_n, empty_n, o_rdy, ae_n, mail_n;
   logic hresp;
   logic [31:0] hrdata;
   logic [35:0] b_data;
   int err_count = 0;
   int n_checks = 0;

   fifo_read_bus_match_flags #(.DEPTH(DEPTH)) fifo_read_bus_match_flags_i (
      .sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .irq_o(irq),
      .bus_match_select_i(bms), .size_select_i(szs), .endian_order_select_i(bes),
      .input_port_clock_i(in_clk), .input_port_select_n_i(a_sel_n), .a_write_i(1'b1),
      .input_mailbox_select_i(a_mb), .a_data_i(a_data), .full_indicator_n_o(full_n),
      .input_space_ready_o(ir), .almost_full_indicator_n_o(af_n),
      .output_port_clock_i(out_clk), .output_port_select_n_i(b_sel_n), .b_read_i(1'b1),
      .output_mailbox_select_i(b_mb), .b_data_o(b_data), .empty_indicator_n_o(empty_n),
      .output_ready_o(o_rdy), .almost_empty_indicator_n_o(ae_n),
      .a_to_b_mail_flag_n_o(mail_n));
   fifo_far_side_model fifo_far_side_model_i (.sys_clk_i(clk), .slow_i(slow),
      .input_port_clock_o(in_clk), .output_port_clock_o(out_clk));

   // 100 MHz system clock
   initial begin
      forever #5 clk = ~clk;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // every open-ended wait goes through here, so a hang ends the run
   task automatic step(inout int n);
      @(posedge clk);
      n++;
      if (n > 400) begin
         err_count++;
         $display("BAD %0t wait timed out", $time);
         test_done();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      hsel <= 1'b1;
      hwrite <= wr;
      haddr <= {24'h0, a};
      htrans <= fifo_rbm_pkg::HTRANS_NONSEQ;
      step(n);
      while (!hreadyout) step(n);
      htrans <= 2'h0;
      hwdata <= d;
      step(n);
      while (!hreadyout) step(n);
      // select stays up with htrans idle; each following call drives it high again
      q = hrdata;
   endtask
   task automatic do_reset(input logic bm, input logic sz, input logic be);
      rst <= 1'b1;
      bms <= bm;
      szs <= sz;
      bes <= be;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
   endtask
   // a request stands until the port edge takes it; released data is inverted
   task automatic port_wr(input logic mb, input logic [35:0] d);
      int n;
      n = 0;
      a_sel_n <= 1'b0;
      a_mb <= mb;
      a_data <= d;
      step(n);
      while (!in_clk) step(n);
      a_sel_n <= 1'b1;
      a_data <= ~d;
      #1;
   endtask
   // pre: data shown before the read edge (mailbox, fall-through) is taken
   task automatic port_rd(input logic mb, input logic pre, output logic [35:0] q);
      int n;
      n = 0;
      b_sel_n <= 1'b0;
      b_mb <= mb;
      step(n);
      while (!out_clk) step(n);
      q = b_data;
      b_sel_n <= 1'b1;
      b_mb <= 1'b0;
      #1;
      if (!pre) q = b_data;
   endtask
   // counts port edges until empty (0), output ready (1) or full (2) flag rises
   task automatic pulses(input int which, output int k);
      int n;
      n = 0;
      k = 0;
      while (!(which == 0 ? empty_n : which == 1 ? o_rdy : full_n)) begin
         step(n);
         if (which == 2 ? in_clk : out_clk) k++;
         #1;
      end
   endtask
   function automatic logic [35:0] piece(input logic [35:0] w, input int pc, input int j);
      int wd;
      wd = 36 / pc;
      return (w >> ((pc - 1 - j) * wd)) & ((36'h1 << wd) - 36'h1);
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic reg_run();
      logic [31:0] r;
      logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40};
      logic [31:0] exp [5] = '{32'h0, 32'h8, 32'h8, 32'h2a, 32'h0};
      do_reset(1'b0, 1'b0, 1'b0);
      ahb(1'b1, 8'h40, 32'hffff_ffff, r);
      for (int i = 0; i < 5; i++) begin
         ahb(1'b0, adr[i], 32'h0, r);
         check(r, exp[i]);
         check(hresp, 1'b0);
      end
   endtask
   task automatic mode_run(input logic bm, input logic sz, input logic be);
      logic [35:0] w, q;
      int k, pc;
      w = 36'h9_a5c3_e718;
      do_reset(bm, sz, be);
      pc = !bm ? 1 : sz ? 4 : 2;
      port_wr(1'b0, w);
      pulses(0, k);
      check(k == 1 || k == 2, 1'b1);
      for (int i = 0; i < pc; i++) begin
         check(empty_n, 1'b1);
         port_rd(1'b0, 1'b0, q);
         check(q, piece(w, pc, be ? i : pc - 1 - i));
      end
      check(empty_n, 1'b0);
      port_wr(1'b1, ~w);
      check(mail_n, 1'b0);
      port_wr(1'b1, w);
      port_rd(1'b1, 1'b1, q);
      check(q, piece(~w, pc, pc - 1));
      check(mail_n, 1'b1);
   endtask
   task automatic fall_through_mode_run();
      logic [31:0] r;
      logic [35:0] q, w;
      int k;
      w = 36'h1_2345_6789;
      do_reset(1'b1, 1'b0, 1'b1);
      slow <= 1'b1;
      ahb(1'b1, fifo_rbm_pkg::CTRL_OFS, 32'h1, r);
      port_wr(1'b0, w);
      pulses(1, k);
      check(k == 3 || k == 4, 1'b1);
      check(ir, 1'b1);
      port_rd(1'b0, 1'b1, q);
      check(q, piece(w, 2, 0));
      check(o_rdy, 1'b1);
      port_rd(1'b0, 1'b1, q);
      check(q, piece(w, 2, 1));
      check(o_rdy, 1'b0);
      slow <= 1'b0;
   endtask
   task automatic full_run();
      logic [31:0] r;
      logic [35:0] q;
      int k, n;
      do_reset(1'b0, 1'b0, 1'b0);
      ahb(1'b1, fifo_rbm_pkg::IRQ_MASK_OFS, 32'h2, r);
      for (int i = 0; i <= DEPTH; i++) port_wr(1'b0, 36'(i));
      check(full_n, 1'b0);
      check(af_n, 1'b0);
      check(irq, 1'b1);
      ahb(1'b1, fifo_rbm_pkg::IRQ_STATUS_OFS, 32'h2, r);
      ahb(1'b0, fifo_rbm_pkg::IRQ_STATUS_OFS, 32'h0, r);
      check(r, 36'h0);
      check(irq, 1'b0);
      check(ae_n, 1'b1);
      for (int i = 0; i < DEPTH; i++) begin
         port_rd(1'b0, 1'b0, q);
         check(q, 36'(i));
         if (i == 0) pulses(2, k);
         if (i == 0) check(k == 1 || k == 2, 1'b1);
      end
      n = 0;
      while (!af_n) step(n);
      check(af_n, 1'b1);
      check(ae_n, 1'b0);
      check(empty_n, 1'b0);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      reg_run();
      mode_run(1'b0, 1'b0, 1'b0);
      mode_run(1'b1, 1'b0, 1'b1);
      mode_run(1'b1, 1'b0, 1'b0);
      mode_run(1'b1, 1'b1, 1'b1);
      mode_run(1'b1, 1'b1, 1'b0);
      fall_through_mode_run();
      full_run();
      test_done();
   end
endmodule
`default_nettype wire
